/* File: inc/dcswt_pkg.sv */
package dcswt_pkg;
  // ==========================================================
  // register map
  localparam logic [6:0] ctrl_addr = 7'h06;
  localparam logic [15:0] ctrl_reset = 16'h0000;
  localparam logic [15:0] ctrl_wmask = 16'heff7;
  localparam int on2_lsb = 13;
  localparam int per2_lsb = 9;
  localparam int wake_lsb = 7;
  localparam int on1_lsb = 4;
  localparam int per1_lsb = 0;
  // ==========================================================
  // codes
  localparam logic [2:0] on_off_low = 3'h0;
  localparam logic [2:0] on_off_high = 3'h6;
  localparam logic [2:0] on_resvd = 3'h7;
  localparam logic [1:0] wake_none = 2'h0;
  localparam logic [1:0] wake_first = 2'h1;
  localparam logic [1:0] wake_second = 2'h2;
  localparam logic [2:0] filt_timer1 = 3'h2;
  localparam logic [2:0] filt_timer2 = 3'h3;
  // ==========================================================
  // timing: tick of 0.1 ms from a 25 MHz clock
  localparam int clk_khz = 25000;
  localparam int tick_us = 100;
  localparam int tick_cycles = clk_khz * tick_us / 1000;
  localparam int filt_us = 16;
  localparam int filt_cycles = (clk_khz * filt_us + 999) / 1000;
  localparam int cnt_w = 15;
  // on-time in ticks; 0.3 ms = 3 ticks
  localparam logic [14:0] on_t1 = 15'h0001;
  localparam logic [14:0] on_t2 = 15'h0003;
  localparam logic [14:0] on_t3 = 15'h000a;
  localparam logic [14:0] on_t4 = 15'h0064;
  localparam logic [14:0] on_t5 = 15'h00c8;
  // periods in ticks, 10 ms .. 2 s
  localparam logic [14:0] per_t0 = 15'h0064;
  localparam logic [14:0] per_t1 = 15'h00c8;
  localparam logic [14:0] per_t2 = 15'h01f4;
  localparam logic [14:0] per_t3 = 15'h03e8;
  localparam logic [14:0] per_t4 = 15'h07d0;
  localparam logic [14:0] per_t5 = 15'h1388;
  localparam logic [14:0] per_t6 = 15'h2710;
  localparam logic [14:0] per_t7 = 15'h4e20;
endpackage

/* File: inc/dcswt_tmr_if.sv */
`timescale 1ns/1ps
interface dcswt_tmr_if;
  logic tick;
  logic [2:0] on_code;
  logic [2:0] per_code;
  logic out;
  logic on_end;
  logic per_end;
  modport ctl (output tick, output on_code, output per_code,
               input out, input on_end, input per_end);
  modport tmr (input tick, input on_code, input per_code,
               output out, output on_end, output per_end);
endinterface

/* File: src/dcswt_timer.sv */
`timescale 1ns/1ps
module dcswt_timer (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic clk_en,
  dcswt_tmr_if.tmr t
);
  typedef struct packed {
    logic [14:0] cnt;
    logic out;
    logic on_end;
    logic per_end;
    logic [2:0] last_on;
  } dcswt_tst_t;
  dcswt_tst_t s_q, s_d;
  logic [14:0] on_len, per_len;
  logic run;

  // ==========================================================
  // code tables shared by both timers
  always_comb begin
    unique case (t.on_code)
      3'h1: on_len = dcswt_pkg::on_t1;
      3'h2: on_len = dcswt_pkg::on_t2;
      3'h3: on_len = dcswt_pkg::on_t3;
      3'h4: on_len = dcswt_pkg::on_t4;
      3'h5: on_len = dcswt_pkg::on_t5;
      default: on_len = '0; // stopped codes
    endcase
    unique case (t.per_code)
      3'h0: per_len = dcswt_pkg::per_t0;
      3'h1: per_len = dcswt_pkg::per_t1;
      3'h2: per_len = dcswt_pkg::per_t2;
      3'h3: per_len = dcswt_pkg::per_t3;
      3'h4: per_len = dcswt_pkg::per_t4;
      3'h5: per_len = dcswt_pkg::per_t5;
      3'h6: per_len = dcswt_pkg::per_t6;
      3'h7: per_len = dcswt_pkg::per_t7;
    endcase
    run = on_len != '0;
  end

  // ==========================================================
  // counting: on-time at the head of every period
  always_comb begin
    s_d = s_q;
    s_d.on_end = 1'b0;
    s_d.per_end = 1'b0;
    s_d.last_on = t.on_code;
    if (!run) begin
      s_d.cnt = '0;
      s_d.out = t.on_code >= dcswt_pkg::on_off_high; // [R1] [R2] [R3]
    end else if (t.on_code != s_q.last_on) begin
      s_d.cnt = '0; // new running code starts at once [R9]
      s_d.out = 1'b1;
    end else if (t.tick) begin
      if (s_q.out && s_q.cnt + 15'h0001 == on_len) begin
        s_d.out = 1'b0;
        s_d.on_end = 1'b1;
      end
      // wrap comes last: an on-time equal to or longer than the period keeps the output high
      if (s_q.cnt + 15'h0001 >= per_len) begin
        s_d.cnt = '0;
        s_d.out = 1'b1; // [R13]
        s_d.per_end = 1'b1;
      end else begin
        s_d.cnt = s_q.cnt + 15'h0001;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      s_q <= '0;
    end else if (clk_en) begin
      s_q <= s_d;
    end
  end

  assign t.out = s_q.out;
  assign t.on_end = s_q.on_end;
  assign t.per_end = s_q.per_end;
endmodule

/* File: src/dcswt_top.sv */
`timescale 1ns/1ps
// What this block does
// [R1] second timer on-time at bits 15:13; 000 low, 110 high, 001 to 101 durations
// [R2] first timer on-time at bits 6:4 with the same table
// [R3] on-time code 111 behaves as 110: stopped, output high
// [R4] second timer period at bits 11:9, 10 ms up to 2 s
// [R5] first timer period at bits 2:0, same eight periods
// [R6] bits 8:7 choose wake source: none, first, second, 11 reserved
// [R7] bits 12 and 3 read zero and ignore writes
// [R8] power-on, soft reset and restart entry clear the register
// [R9] timer starts by itself once a running on-time is written
// [R10] restart clearing a cyclic-sense switch also clears timer settings
// [R11] cyclic sense and cyclic wake may run together off one timer
// [R12] timer-filtered wake input sampled 16 us at end of on-time
// [R13] periods repeat; output high for on-time at each period start
// [R14] one wake event per completed period of the chosen timer
module dcswt_top #(
  // tick length in clock cycles; a bench may shorten it to reach whole periods
  parameter int tick_len = dcswt_pkg::tick_cycles
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire logic reg_wr,
  input wire logic [6:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic soft_rst,
  input wire logic restart_entry,
  input wire logic [1:0] hs_cleared,
  input wire logic [2:0] wake_filter_select,
  input wire logic wake_pin,
  output logic [15:0] reg_rdata,
  output logic first_high_side_output,
  output logic second_high_side_output,
  output logic wake_event,
  output logic [1:0] wake_cause,
  output logic wake_sample_valid,
  output logic wake_sample
);
  typedef struct packed {
    logic [15:0] ctrl;
    logic [15:0] rdata;
    logic [11:0] tick_cnt;
    logic tick;
    logic o1;
    logic o2;
    logic wev;
    logic [1:0] cause;
    logic [9:0] filt_cnt;
    logic filt_busy;
    logic filt_ok;
    logic sval;
    logic sbit;
    logic [1:0] pin_sync;
  } dcswt_st_t;
  dcswt_st_t s_q, s_d;

  dcswt_tmr_if t1 ();
  dcswt_tmr_if t2 ();

  // ==========================================================
  // timers
  assign t1.tick = s_q.tick;
  assign t2.tick = s_q.tick;
  assign t1.on_code = s_q.ctrl[dcswt_pkg::on1_lsb +: 3]; // [R2]
  assign t1.per_code = s_q.ctrl[dcswt_pkg::per1_lsb +: 3]; // [R5]
  assign t2.on_code = s_q.ctrl[dcswt_pkg::on2_lsb +: 3]; // [R1]
  assign t2.per_code = s_q.ctrl[dcswt_pkg::per2_lsb +: 3]; // [R4]

  dcswt_timer u_t1 (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .clk_en(clk_en),
    .t(t1.tmr)
  );
  dcswt_timer u_t2 (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .clk_en(clk_en),
    .t(t2.tmr)
  );

  // ==========================================================
  // next state
  always_comb begin
    s_d = s_q;
    s_d.pin_sync = {s_q.pin_sync[0], wake_pin};
    // oscillator-derived tick shared by both timers [R13]
    s_d.tick = 1'b0;
    if (s_q.tick_cnt == 12'(tick_len - 1)) begin
      s_d.tick_cnt = '0;
      s_d.tick = 1'b1;
    end else begin
      s_d.tick_cnt = s_q.tick_cnt + 12'h001;
    end
    // register write; reserved bits masked out [R7]
    if (reg_wr && reg_addr == dcswt_pkg::ctrl_addr) begin
      s_d.ctrl = reg_wdata & dcswt_pkg::ctrl_wmask; // [R9]
    end
    // restart clears the fields of each timer whose switch was cleared; the full clear below then clears all of them [R10]
    if (restart_entry && hs_cleared[0]) begin
      s_d.ctrl[dcswt_pkg::on1_lsb +: 3] = 3'h0;
      s_d.ctrl[dcswt_pkg::per1_lsb +: 3] = 3'h0;
    end
    if (restart_entry && hs_cleared[1]) begin
      s_d.ctrl[dcswt_pkg::on2_lsb +: 3] = 3'h0;
      s_d.ctrl[dcswt_pkg::per2_lsb +: 3] = 3'h0;
    end
    // full clear wins over everything else [R8]
    if (soft_rst || restart_entry) begin
      s_d.ctrl = dcswt_pkg::ctrl_reset;
    end
    s_d.rdata = s_q.ctrl & dcswt_pkg::ctrl_wmask; // [R7]
    s_d.o1 = t1.out;
    s_d.o2 = t2.out;
    // wake runs beside sensing, independent of the outputs [R11]
    s_d.wev = 1'b0;
    unique case (s_q.ctrl[dcswt_pkg::wake_lsb +: 2]) // [R6]
      dcswt_pkg::wake_first: begin
        if (t1.per_end) begin
          s_d.wev = 1'b1; // [R14]
          s_d.cause = dcswt_pkg::wake_first;
        end
      end
      dcswt_pkg::wake_second: begin
        if (t2.per_end) begin
          s_d.wev = 1'b1; // [R14]
          s_d.cause = dcswt_pkg::wake_second;
        end
      end
      default: ; // none or reserved: no wake
    endcase
    // 16 us filter window started at end of on-time [R12]
    s_d.sval = 1'b0;
    if ((wake_filter_select == dcswt_pkg::filt_timer1 && t1.on_end) ||
        (wake_filter_select == dcswt_pkg::filt_timer2 && t2.on_end)) begin
      s_d.filt_busy = 1'b1;
      s_d.filt_cnt = '0;
      s_d.filt_ok = 1'b1;
      s_d.sbit = s_q.pin_sync[1];
    end else if (s_q.filt_busy) begin
      // level must stay steady through the whole window
      if (s_q.pin_sync[1] != s_q.sbit) begin
        s_d.filt_ok = 1'b0;
      end
      if (s_q.filt_cnt == 10'(dcswt_pkg::filt_cycles - 1)) begin
        s_d.filt_busy = 1'b0;
        s_d.sval = s_q.filt_ok && s_q.pin_sync[1] == s_q.sbit; // [R12]
      end else begin
        s_d.filt_cnt = s_q.filt_cnt + 10'h001;
      end
    end
  end

  // ==========================================================
  // state register; synchronous reset clears control [R8]
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      s_q <= '0;
    end else if (clk_en) begin
      s_q <= s_d;
    end
  end

  assign reg_rdata = s_q.rdata;
  assign first_high_side_output = s_q.o1;
  assign second_high_side_output = s_q.o2;
  assign wake_event = s_q.wev;
  assign wake_cause = s_q.cause;
  assign wake_sample_valid = s_q.sval;
  assign wake_sample = s_q.sbit;
endmodule

/* File: dv/dcswt_props.sv */
`timescale 1ns/1ps
// ==========================================================
// port checks of the timer block
module dcswt_props (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire logic reg_wr,
  input wire logic [6:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic soft_rst,
  input wire logic restart_entry,
  input wire logic [15:0] reg_rdata,
  input wire logic first_high_side_output,
  input wire logic second_high_side_output,
  input wire logic wake_event,
  input wire logic [1:0] wake_cause
);
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rst_n);
  logic wr_ok;
  logic calm;
  // a clear in the same cycle wins, so it spoils the write
  assign wr_ok = clk_en && reg_wr && reg_addr == dcswt_pkg::ctrl_addr && !soft_rst && !restart_entry;
  assign calm = clk_en && !reg_wr && !soft_rst && !restart_entry;
  readback_a: assert property (
    wr_ok ##1 calm ##1 calm |=> reg_rdata == ($past(reg_wdata, 3) & 16'heff7))
    else $error("readback wrong");
  resv_zero_a: assert property (!reg_rdata[12] && !reg_rdata[3])
    else $error("reserved bit set");
  clear_a: assert property ((soft_rst || restart_entry) && clk_en ##1 calm |=> reg_rdata == 16'h0)
    else $error("register not cleared");
  first_low_a: assert property (
    (clk_en && reg_rdata[6:4] == 3'h0) [*4] |-> !first_high_side_output)
    else $error("first output not low");
  first_high_a: assert property (
    (clk_en && reg_rdata[6:4] >= 3'h6) [*4] |-> first_high_side_output)
    else $error("first output not high");
  second_low_a: assert property (
    (clk_en && reg_rdata[15:13] == 3'h0) [*4] |-> !second_high_side_output)
    else $error("second output not low");
  second_high_a: assert property (
    (clk_en && reg_rdata[15:13] >= 3'h6) [*4] |-> second_high_side_output)
    else $error("second output not high");
  wake_off_a: assert property ((clk_en && reg_rdata[8:7] == 2'h0) [*4] |-> !wake_event)
    else $error("wake with no source");
  wake_cause_a: assert property (wake_event |-> wake_cause == reg_rdata[8:7] ##1 !wake_event)
    else $error("wake cause or pulse wrong");
  cover property (wr_ok);
  cover property ($rose(first_high_side_output));
  cover property (soft_rst || restart_entry);
  cover property (wake_event);
endmodule
bind dcswt_top dcswt_props u_props (.ref_clk(ref_clk), .rst_n(rst_n), .clk_en(clk_en),
  .reg_wr(reg_wr), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .soft_rst(soft_rst),
  .restart_entry(restart_entry), .reg_rdata(reg_rdata), .wake_event(wake_event),
  .first_high_side_output(first_high_side_output), .wake_cause(wake_cause),
  .second_high_side_output(second_high_side_output));

/* File: dv/dcswt_wake_model.sv */
`timescale 1ns/1ps
// ==========================================================
// static wake contact: the pin level lags the contact by two cycles
module dcswt_wake_model (
  input wire logic ref_clk,
  input wire logic contact,
  output logic wake_pin
);
  logic [1:0] dly_q = 2'h0;
  // the lag keeps the pin edge away from the bench's own drive edge
  always_ff @(posedge ref_clk) begin
    dly_q <= {dly_q[0], contact};
  end
  assign wake_pin = dly_q[1];
endmodule

/* File: dv/test_dual_cyclic_sense_wake_timer.sv */
`timescale 1ns/1ps
// ==========================================================
// register and timer sequences
module test_dual_cyclic_sense_wake_timer;
  logic ref_clk = 1'b0, rst_n = 1'b0, reg_wr = 1'b0, soft_rst = 1'b0, restart_entry = 1'b0;
  logic contact = 1'b0, wake_pin, o1, o2, wake_event, wake_sample_valid, wake_sample;
  logic [6:0] reg_addr = 7'h00;
  logic [15:0] reg_wdata = 16'h0000, reg_rdata, d, rv;
  logic [1:0] hs_cleared = 2'h0, wake_cause;
  logic [2:0] wake_filter_select = 3'h0;
  int fail_count = 0, num_checks = 0, n;
  // one 0.1 ms tick shortened to 10 cycles so whole periods fit the run
  localparam int tb_tick = 10;
  localparam int per_len = 100 * tb_tick; // 10 ms period
  localparam int filt_len = 400; // 16 us at 25 MHz
  initial forever #20 ref_clk = ~ref_clk;
  dcswt_top #(.tick_len(tb_tick)) u_dut (.ref_clk(ref_clk), .rst_n(rst_n), .clk_en(1'b1),
    .reg_wr(reg_wr),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .soft_rst(soft_rst),
    .restart_entry(restart_entry), .hs_cleared(hs_cleared), .wake_pin(wake_pin),
    .wake_filter_select(wake_filter_select), .reg_rdata(reg_rdata),
    .first_high_side_output(o1), .second_high_side_output(o2), .wake_event(wake_event),
    .wake_cause(wake_cause), .wake_sample_valid(wake_sample_valid), .wake_sample(wake_sample));
  dcswt_wake_model u_wake (.ref_clk(ref_clk), .contact(contact), .wake_pin(wake_pin));
  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // one-cycle strobe, then settle time before anything is sampled
  task automatic wr(input logic [6:0] a, input logic [15:0] v);
    @(posedge ref_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
    repeat (5) @(posedge ref_clk);
    @(negedge ref_clk);
  endtask
  // readback stands on its own port; take it half a cycle after an edge
  task automatic rd(output logic [15:0] v);
    @(negedge ref_clk);
    v = reg_rdata;
  endtask
  task automatic clr(input logic which);
    wr(7'h06, 16'h60e0);
    @(posedge ref_clk);
    if (which) soft_rst <= 1'b1;
    else restart_entry <= 1'b1;
    hs_cleared <= 2'h3;
    @(posedge ref_clk);
    soft_rst <= 1'b0;
    restart_entry <= 1'b0;
    hs_cleared <= 2'h0;
    repeat (5) @(negedge ref_clk);
    chk("cleared", reg_rdata, 16'h0000);
    chk("outs cleared", {o1, o2}, 16'h0);
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  initial begin
    repeat (60000) @(posedge ref_clk);
    fail_count++;
    finish_test();
  end
  initial begin
    repeat (5) @(posedge ref_clk);
    rst_n <= 1'b1;
    @(negedge ref_clk);
    chk("reset value", reg_rdata, 16'h0000);
    wr(7'h06, 16'hffff);
    chk("masked", reg_rdata, 16'heff7);
    chk("code 7 outs", {o1, o2}, 16'h3);
    // every code of every field; stop codes also fix the outputs
    for (int i = 0; i < 8; i++) begin
      d = {i[2:0], 1'b0, i[2:0], i[1:0], i[2:0], 1'b0, i[2:0]};
      wr(7'h06, d);
      rd(rv);
      chk("fields", rv, d);
      if (i == 0 || i > 5) chk("stop outs", {o1, o2}, (i == 0) ? 16'h0 : 16'h3);
    end
    wr(7'h07, 16'h1234);
    chk("other addr", reg_rdata, d);
    clr(1'b1);
    clr(1'b0);
    // first timer, 0.1 ms on-time, 10 ms period, filtered by the first timer
    @(posedge ref_clk);
    contact <= 1'b1;
    wake_filter_select <= 3'h2;
    wr(7'h06, 16'h0010);
    // skip the first on-time, which the free-running tick may cut short
    for (n = 0; o1 === 1'b1 && n < 3000; n++) @(negedge ref_clk);
    for (n = 0; o1 !== 1'b1 && n < 3000; n++) @(negedge ref_clk);
    for (n = 0; o1 === 1'b1 && n < 3000; n++) @(negedge ref_clk);
    chk("on time", 16'(n), 16'(tb_tick));
    for (n = 0; wake_sample_valid !== 1'b1 && n < 3000; n++) @(negedge ref_clk);
    chk("filter window", 16'(n), 16'(filt_len));
    chk("filtered level", {15'h0, wake_sample}, 16'h1);
    chk("no wake source", {15'h0, wake_event}, 16'h0);
    // same timer chosen as wake source while it keeps sensing
    wr(7'h06, 16'h0090);
    for (n = 0; wake_event !== 1'b1 && n < 3000; n++) @(negedge ref_clk);
    chk("first wake seen", {15'h0, wake_event}, 16'h1);
    chk("first cause", {14'h0, wake_cause}, 16'h1);
    chk("sense beside wake", {15'h0, o1}, 16'h1);
    for (n = 0; o1 === 1'b1 && n < 3000; n++) @(negedge ref_clk);
    for (n = 0; o1 !== 1'b1 && n < 3000; n++) @(negedge ref_clk);
    chk("period low", 16'(n), 16'(per_len - tb_tick));
    // hand sensing and wake over to the second timer
    wr(7'h06, 16'h2100);
    for (n = 0; wake_event !== 1'b1 && n < 3000; n++) @(negedge ref_clk);
    chk("second wake seen", {15'h0, wake_event}, 16'h1);
    chk("second cause", {14'h0, wake_cause}, 16'h2);
    chk("second senses", {15'h0, o2}, 16'h1);
    chk("first stopped", {15'h0, o1}, 16'h0);
    finish_test();
  end
endmodule
